// *** rtl/dcsp_map.vh ***
// constants for the synthesizer programming-port controller
// Notes on behaviour
// (R01) divide load: code 10, D-1 LSB first
// (R02) multiply load: code 11, M-1 LSB first
// (R03) commit: single 0 bit, one-cycle enable
// (R04) divide, multiply, commit; two idle between loads
// (R05) one idle cycle before commit
// (R06) wait for programming complete high
// (R07) new frequency valid once lock rises
// (R08) loaded values replace static multiply, divide
// (R09) one enable per slave, watch each complete
// (R10) fixed spread modulates at input over 1024
// (R11) fixed spread output must exceed 50 MHz
// (R12) soft spread needs continuous reprogramming logic; here left to software re-running the sequencer
// (R13) soft spread static multiply 7, divide 2/4
// (R14) soft spread modes fast, medium, slow
// (R15) free-run: lock tied to output hold input
// (R16) reference must toggle steadily until lock
// (R17) new reference clock requires reset
// (R18) hold synthesizer reset three reference cycles
// (R19) stopped-reference status not sticky
// (R20) lost lock needs reset to reacquire
// (R21) sample enable and data on shift clock rise
`ifndef DCSP_MAP_VH
`define DCSP_MAP_VH
// ****************************************
// register offsets
// ****************************************
`define DCSP_REG_CTRL    8'h00
`define DCSP_REG_VALUES  8'h04
`define DCSP_REG_STATUS  8'h08
`define DCSP_REG_SPREAD  8'h0c
// ****************************************
// field positions
// ****************************************
`define DCSP_CTRL_GO     0
`define DCSP_CTRL_RST    1
`define DCSP_CTRL_HOLD   2
`define DCSP_CTRL_FREE   3
`define DCSP_ST_BUSY     0
`define DCSP_ST_DONE     1
`define DCSP_ST_LOCK     2
`define DCSP_ST_STOP     3
`define DCSP_ST_LOST     4
`define DCSP_ST_SEL_LO   8
// ****************************************
// command codes, timing and reset values
// ****************************************
`define DCSP_CODE_LOAD_DIVISOR_CMD  2'b10
`define DCSP_CODE_LOAD_MULTIPLIER_CMD  2'b11
`define DCSP_CMD_BITS    10
`define DCSP_GAP_DM      2
`define DCSP_GAP_MG      1
`define DCSP_RST_CYC     3
`define DCSP_RST_VAL     32'h00000000
`define DCSP_VAL_RST     32'h00000601
`define DCSP_D1_RST      8'h01
`define DCSP_M1_RST      8'h06
`endif

// *** rtl/dcsp_shift_reg.v ***
// serial frame shifter for one programming command
`timescale 1ns/1ps
`default_nettype none
module dcsp_shift_reg #(
  parameter WIDTH = 10
) (
  input  wire             ref_clk,
  input  wire             rst_b,
  input  wire             load,
  input  wire [WIDTH-1:0] loadData,
  input  wire             shift,
  output wire             serialBit
);
  reg [WIDTH-1:0] data_q;
  assign serialBit = data_q[0];
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= {WIDTH{1'b0}};
    end else if (load) begin
      data_q <= loadData;
    end else if (shift) begin
      data_q <= {1'b0, data_q[WIDTH-1:1]};
    end
  end
endmodule
`default_nettype wire

// *** rtl/dcsp_prog_master.v ***
// programming master for a dynamically programmable clock synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "dcsp_map.vh"
module dcsp_prog_master #(
  parameter NSLAVE = 1,
  parameter SELW   = 1
) (
  input  wire              ref_clk,
  input  wire              rst_b,
  // ahb-lite slave
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire              hresp,
  output reg  [31:0]       hrdata,
  // synthesizer pins
  output reg               prog_shift_clock,
  output reg  [NSLAVE-1:0] prog_frame_enable,
  output wire              prog_serial_in,
  input  wire [NSLAVE-1:0] prog_complete,
  input  wire [NSLAVE-1:0] synth_locked,
  input  wire [NSLAVE-1:0] ref_stopped,
  output reg               synth_reset,
  output reg               output_hold_input,
  output reg  [1:0]        spread_mode
);
  // ****************************************
  // states
  // ****************************************
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_LOAD_DIVISOR_CMD = 3'd1;
  localparam [2:0] ST_GAP1 = 3'd2;
  localparam [2:0] ST_LOAD_MULTIPLIER_CMD = 3'd3;
  localparam [2:0] ST_GAP2 = 3'd4;
  localparam [2:0] ST_GO = 3'd5;
  localparam [2:0] ST_WAIT = 3'd6;
  localparam [2:0] ST_RST = 3'd7;

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [NSLAVE-1:0] doneS1_q, doneS2_q, lockS1_q, lockS2_q;
  reg [NSLAVE-1:0] stopS1_q, stopS2_q;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      doneS1_q <= {NSLAVE{1'b0}};
      doneS2_q <= {NSLAVE{1'b0}};
      lockS1_q <= {NSLAVE{1'b0}};
      lockS2_q <= {NSLAVE{1'b0}};
      stopS1_q <= {NSLAVE{1'b0}};
      stopS2_q <= {NSLAVE{1'b0}};
    end else begin
      doneS1_q <= prog_complete;
      doneS2_q <= doneS1_q;
      lockS1_q <= synth_locked;
      lockS2_q <= lockS1_q;
      stopS1_q <= ref_stopped;
      stopS2_q <= stopS1_q;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg [7:0]      dMinus1_q, mMinus1_q;
  reg [SELW-1:0] sel_q;
  reg            hold_q, free_q, lost_q, lockD_q;
  reg [1:0]      spread_q;
  reg [2:0]      state_q;
  reg            clkPh_q;
  reg [3:0]      bitCnt_q;
  reg [1:0]      rstCnt_q;
  reg            goReq, rstReq;
  reg            goPend_q, rstPend_q;

  // ahb-lite: address phase captured, zero wait states
  reg        wrPend_q;
  reg [7:0]  wrAddr_q;
  wire       acc = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= acc & hwrite;
      if (acc) begin
        wrAddr_q <= haddr[7:0];
      end
    end
  end

  function [0:0] sel_bit;
    input [NSLAVE-1:0] vec;
    input [SELW-1:0]   idx;
    begin
      sel_bit = vec[idx];
    end
  endfunction

  // one enable per slave; a plain shift of a padded one breaks at one slave
  function [NSLAVE-1:0] one_hot;
    input [SELW-1:0] idx;
    integer k;
    begin
      for (k = 0; k < NSLAVE; k = k + 1) begin
        one_hot[k] = (idx == k);
      end
    end
  endfunction

  wire curDone = sel_bit(doneS2_q, sel_q);
  wire curLock = sel_bit(lockS2_q, sel_q);
  wire curStop = sel_bit(stopS2_q, sel_q);
  wire busy    = (state_q != ST_IDLE) | goPend_q | rstPend_q;

  always @* begin
    goReq  = wrPend_q & (wrAddr_q == `DCSP_REG_CTRL) & ~busy
             & hwdata[`DCSP_CTRL_GO];
    rstReq = wrPend_q & (wrAddr_q == `DCSP_REG_CTRL) & ~busy
             & hwdata[`DCSP_CTRL_RST];
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dMinus1_q <= `DCSP_D1_RST; // R13
      mMinus1_q <= `DCSP_M1_RST; // R13
      sel_q     <= {SELW{1'b0}};
      hold_q    <= 1'b0;
      free_q    <= 1'b0;
      spread_q  <= 2'b00;
    end else if (wrPend_q) begin
      case (wrAddr_q)
        `DCSP_REG_CTRL: begin
          hold_q <= hwdata[`DCSP_CTRL_HOLD];
          free_q <= hwdata[`DCSP_CTRL_FREE];
        end
        `DCSP_REG_VALUES: begin
          if (!busy) begin
            dMinus1_q <= hwdata[7:0];
            mMinus1_q <= hwdata[15:8];
            sel_q     <= hwdata[16 +: SELW];
          end
        end
        // fixed spread needs M/D giving over 50 MHz; software must check
        `DCSP_REG_SPREAD: spread_q <= hwdata[1:0]; // R11
        default: ;
      endcase
    end
  end

  // lost lock stays flagged until a reset sequence
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lockD_q <= 1'b0;
      lost_q  <= 1'b0;
    end else begin
      lockD_q <= curLock;
      if (lockD_q & ~curLock) begin
        lost_q <= 1'b1; // R20
      end else if (state_q == ST_RST) begin
        lost_q <= 1'b0;
      end
    end
  end

  // read data latched at the address phase, so it stands steady through
  // the data phase even while status pins move
  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h00000000;
    case (haddr[7:0])
      `DCSP_REG_CTRL: begin
        rdMux[`DCSP_CTRL_HOLD] = hold_q;
        rdMux[`DCSP_CTRL_FREE] = free_q;
      end
      `DCSP_REG_VALUES: rdMux[15:0] = {mMinus1_q, dMinus1_q};
      `DCSP_REG_STATUS: begin
        rdMux[`DCSP_ST_BUSY] = busy;
        rdMux[`DCSP_ST_DONE] = curDone;
        rdMux[`DCSP_ST_LOCK] = curLock;
        rdMux[`DCSP_ST_STOP] = curStop; // R19
        rdMux[`DCSP_ST_LOST] = lost_q;
      end
      `DCSP_REG_SPREAD: rdMux[1:0] = spread_q; // R14
      default: rdMux = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (acc & ~hwrite) begin
      hrdata <= rdMux;
    end
  end

  // ****************************************
  // serial sequencer
  // ****************************************
  // the shift clock is ref_clk divided by two; data and enable change
  // on its falling edge so the slave samples them mid-bit
  wire fallEdge = clkPh_q;
  wire riseNext = ~clkPh_q;

  // a request may land on either shift-clock phase, so it is parked here
  // until the next falling edge; reset wins over a go in the same write
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      goPend_q  <= 1'b0;
      rstPend_q <= 1'b0;
    end else begin
      if (goReq) begin
        goPend_q <= 1'b1;
      end else if (fallEdge & (state_q == ST_IDLE)) begin
        goPend_q <= 1'b0;
      end
      if (rstReq) begin
        rstPend_q <= 1'b1;
      end else if (fallEdge & (state_q == ST_IDLE)) begin
        rstPend_q <= 1'b0;
      end
    end
  end
  reg        shLoad, shShift;
  reg [9:0]  shData;
  always @* begin
    shLoad  = 1'b0;
    shShift = 1'b0;
    shData  = 10'h000;
    if (fallEdge) begin
      case (state_q)
        ST_IDLE: if (goPend_q & ~rstPend_q) begin
          shLoad = 1'b1;
          shData = {dMinus1_q, 2'b01}; // R01
        end
        ST_GAP1: if (bitCnt_q == `DCSP_GAP_DM - 1) begin
          shLoad = 1'b1;
          shData = {mMinus1_q, 2'b11}; // R02
        end
        ST_GAP2: if (bitCnt_q == `DCSP_GAP_MG - 1) begin
          shLoad = 1'b1;
          shData = 10'h000; // R03
        end
        default: shShift = (state_q == ST_LOAD_DIVISOR_CMD) | (state_q == ST_LOAD_MULTIPLIER_CMD);
      endcase
    end
  end

  dcsp_shift_reg #(.WIDTH(`DCSP_CMD_BITS)) uShift (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .load      (shLoad),
    .loadData  (shData),
    .shift     (shShift),
    .serialBit (prog_serial_in)
  );

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q           <= ST_IDLE;
      clkPh_q           <= 1'b0;
      bitCnt_q          <= 4'd0;
      rstCnt_q          <= 2'd0;
      prog_shift_clock  <= 1'b0;
      prog_frame_enable <= {NSLAVE{1'b0}};
      synth_reset       <= 1'b0;
      output_hold_input <= 1'b0;
      spread_mode       <= 2'b00;
    end else begin
      clkPh_q          <= ~clkPh_q;
      prog_shift_clock <= riseNext; // R21
      // soft spread relies on software re-running this sequencer
      spread_mode      <= spread_q; // R12
      // free-run ties lock back to the hold input; hold only follows lock,
      // so the reference must keep running until lock is seen
      output_hold_input <= free_q ? curLock : hold_q; // R15 R16
      if (fallEdge) begin
        case (state_q)
          ST_IDLE: begin
            if (rstPend_q) begin
              state_q     <= ST_RST;
              rstCnt_q    <= 2'd0;
              synth_reset <= 1'b1; // R17
            end else if (goPend_q) begin
              state_q  <= ST_LOAD_DIVISOR_CMD;
              bitCnt_q <= 4'd0;
              prog_frame_enable <= one_hot(sel_q); // R09
            end
          end
          ST_LOAD_DIVISOR_CMD: begin
            if (bitCnt_q == `DCSP_CMD_BITS - 1) begin
              state_q  <= ST_GAP1;
              bitCnt_q <= 4'd0;
              prog_frame_enable <= {NSLAVE{1'b0}};
            end else begin
              bitCnt_q <= bitCnt_q + 4'd1;
            end
          end
          ST_GAP1: begin
            if (bitCnt_q == `DCSP_GAP_DM - 1) begin // R04
              state_q  <= ST_LOAD_MULTIPLIER_CMD;
              bitCnt_q <= 4'd0;
              prog_frame_enable <= one_hot(sel_q);
            end else begin
              bitCnt_q <= bitCnt_q + 4'd1;
            end
          end
          ST_LOAD_MULTIPLIER_CMD: begin
            if (bitCnt_q == `DCSP_CMD_BITS - 1) begin
              state_q  <= ST_GAP2;
              bitCnt_q <= 4'd0;
              prog_frame_enable <= {NSLAVE{1'b0}};
            end else begin
              bitCnt_q <= bitCnt_q + 4'd1;
            end
          end
          ST_GAP2: begin
            if (bitCnt_q == `DCSP_GAP_MG - 1) begin // R05
              state_q <= ST_GO;
              prog_frame_enable <= one_hot(sel_q);
            end else begin
              bitCnt_q <= bitCnt_q + 4'd1;
            end
          end
          ST_GO: begin
            state_q <= ST_WAIT;
            prog_frame_enable <= {NSLAVE{1'b0}}; // R03
          end
          ST_WAIT: begin
            if (curDone) begin
              state_q <= ST_IDLE; // R06
            end
          end
          ST_RST: begin
            // counted in shift-clock periods, well over three ref cycles
            if (rstCnt_q == `DCSP_RST_CYC - 1) begin // R18
              state_q     <= ST_IDLE;
              synth_reset <= 1'b0; // R17
            end else begin
              rstCnt_q <= rstCnt_q + 2'd1;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/dcsp_prog_master_sva.sv ***
// assertions on the programming-port controller pins
`timescale 1ns/1ps
`default_nettype none
module dcsp_prog_master_sva #(
  parameter NSLAVE = 1
) (
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic              prog_shift_clock,
  input wire logic [NSLAVE-1:0] prog_frame_enable,
  input wire logic              prog_serial_in,
  input wire logic              synth_reset
);
  logic       en;
  logic [7:0] hiCnt_q;
  logic [7:0] loCnt_q;
  assign en = |prog_frame_enable;
  // saturating low count so long idle spans never wrap to a short gap
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hiCnt_q <= 8'h00;
      loCnt_q <= 8'h00;
    end else begin
      hiCnt_q <= en ? hiCnt_q + 8'h01 : 8'h00;
      loCnt_q <= en ? 8'h00 : loCnt_q + {7'h00, loCnt_q != 8'hff};
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  AST_BUS_OK: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_FRAME_LEN: assert property (
    $fell(en) |-> hiCnt_q == 8'h14 || hiCnt_q == 8'h02)
    else $error("frame enable length wrong");
  AST_LOAD_LEAD: assert property (
    $fell(en) && hiCnt_q == 8'h14 |-> $past(prog_serial_in, 20))
    else $error("load frame does not lead with a one");
  AST_GO_BIT: assert property (
    $fell(en) && hiCnt_q == 8'h02 |-> !$past(prog_serial_in))
    else $error("commit bit not zero");
  AST_GAP: assert property ($rose(en) |-> loCnt_q >= 8'h02)
    else $error("frames too close");
  AST_EN_EDGE: assert property (
    !$stable({en, prog_serial_in}) |-> !prog_shift_clock)
    else $error("enable or data moved on a rising shift clock");
  AST_RST_LEN: assert property (
    $rose(synth_reset) |-> ##1 synth_reset [*5])
    else $error("synthesizer reset too short");
  AST_COMMIT_QUIET: assert property (
    $fell(en) && hiCnt_q == 8'h02 |-> (!en) [*8])
    else $error("frame right after commit");
endmodule
bind dcsp_prog_master dcsp_prog_master_sva #(.NSLAVE(NSLAVE)) u_sva (
  .ref_clk, .rst_b, .hreadyout, .hresp, .prog_shift_clock,
  .prog_frame_enable, .prog_serial_in, .synth_reset);
`default_nettype wire

// *** verif/dcsp_synth_model.sv ***
// behavioural synthesizer slave behind the programming port
`timescale 1ns/1ps
`default_nettype none
module dcsp_synth_model (
  input  wire logic       prog_shift_clock,
  input  wire logic       prog_frame_enable,
  input  wire logic       prog_serial_in,
  input  wire logic       synth_reset,
  input  wire logic       dropLock,
  input  wire logic       refGone,
  input  wire logic [3:0] doneDelay,
  output var  logic       prog_complete,
  output var  logic       synth_locked,
  output wire logic       ref_stopped,
  output var  logic [7:0] divD1,
  output var  logic [7:0] multM1,
  output var  int         protoErr
);
  logic [9:0] frame;
  int         bits, idle, waitN, step;
  assign ref_stopped = refGone;
  initial begin
    {prog_complete, synth_locked, divD1, multM1, frame} = '0;
    {protoErr, bits, idle, waitN, step} = '0;
  end
  // ********************
  // frame capture
  // ********************
  always @(posedge prog_shift_clock or posedge synth_reset) begin
    if (synth_reset) begin
      synth_locked <= 1'h0;
      step <= 0;
      bits <= 0;
      waitN <= 0;
    end else if (prog_frame_enable) begin
      if (bits == 0 && (step == 1 && idle < 2 || step == 2 && idle < 1))
        protoErr <= protoErr + 1;
      if (bits == 0)
        prog_complete <= 1'h0;
      frame <= {prog_serial_in, frame[9:1]};
      bits <= bits + 1;
      idle <= 0;
    end else begin
      idle <= idle + 1;
      bits <= 0;
      if (bits == 10 && frame[1:0] == 2'h1 && step == 0) begin
        divD1 <= frame[9:2];
        step <= 1;
      end else if (bits == 10 && frame[1:0] == 2'h3 && step == 1) begin
        multM1 <= frame[9:2];
        step <= 2;
      end else if (bits == 1 && !frame[9] && step == 2) begin
        step <= 0;
        waitN <= doneDelay + 1;
      end else if (bits != 0)
        protoErr <= protoErr + 1;
      if (waitN == 1) begin
        prog_complete <= 1'h1;
        synth_locked <= 1'h1;
      end
      if (waitN > 0)
        waitN <= waitN - 1;
    end
    // lock never returns on its own, only a new commit sets it
    if (dropLock)
      synth_locked <= 1'h0;
  end
endmodule
`default_nettype wire

// *** verif/dcsp_prog_master_tb_top.sv ***
// bench for the programming-port controller
`timescale 1ns/1ps
`default_nettype none
`include "dcsp_map.vh"
module dcsp_prog_master_tb_top;
  logic        ref_clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, spread_mode;
  logic [2:0]  hsize;
  logic        prog_shift_clock, prog_frame_enable, prog_serial_in;
  logic        prog_complete, synth_locked, ref_stopped, synth_reset;
  logic        output_hold_input, dropLock, refGone;
  logic [3:0]  doneDelay;
  logic [7:0]  divD1, multM1;
  logic [15:0] vals [3] = '{16'h0d02, 16'h0000, 16'hffff};
  int          protoErr, err_total, checks_done;
  assign hready = hreadyout;
  dcsp_prog_master #(.NSLAVE(1), .SELW(1)) dut (.ref_clk, .rst_b, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .prog_shift_clock, .prog_frame_enable, .prog_serial_in,
    .prog_complete, .synth_locked, .ref_stopped, .synth_reset,
    .output_hold_input, .spread_mode);
  dcsp_synth_model model (.prog_shift_clock, .prog_frame_enable,
    .prog_serial_in, .synth_reset, .dropLock, .refGone, .doneDelay,
    .prog_complete, .synth_locked, .ref_stopped, .divD1, .multM1, .protoErr);
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    if (hready !== 1'h1) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task automatic stWait();
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'h0 && n < 300) begin
      bus(1'h0, `DCSP_REG_STATUS, 32'h0);
      n++;
    end
    if (rd[0] !== 1'h0) begin
      err_total++;
      report_and_stop();
    end
  endtask
  initial begin
    {rst_b, hsel, hwrite, haddr, hwdata, htrans, dropLock, refGone} = '0;
    {doneDelay, err_total, checks_done} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'h1;
    bus(1'h0, `DCSP_REG_CTRL, 32'h0);
    chk(rd, `DCSP_RST_VAL);
    bus(1'h0, `DCSP_REG_VALUES, 32'h0);
    chk(rd, `DCSP_VAL_RST);
    bus(1'h0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 3; i++) begin
      doneDelay <= i[0] ? 4'hc : 4'h0;
      bus(1'h1, `DCSP_REG_VALUES, {16'h0, vals[i]});
      bus(1'h1, `DCSP_REG_CTRL, 32'h1);
      bus(1'h1, `DCSP_REG_VALUES, 32'h5555);
      stWait();
      chk(rd[2:1], 2'h3);
      chk(divD1, vals[i][7:0]);
      chk(multM1, vals[i][15:8]);
      chk(protoErr, 0);
      bus(1'h0, `DCSP_REG_VALUES, 32'h0);
      chk(rd, {16'h0, vals[i]});
    end
    $display("programming done");
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, `DCSP_REG_SPREAD, i);
      repeat (2) @(negedge ref_clk);
      chk(spread_mode, i[1:0]);
    end
    $display("spread modes done");
    bus(1'h1, `DCSP_REG_CTRL, 32'h8);
    repeat (2) @(negedge ref_clk);
    chk(output_hold_input, 1'h1);
    @(posedge ref_clk);
    dropLock <= 1'h1;
    refGone <= 1'h1;
    repeat (8) @(posedge ref_clk);
    chk(output_hold_input, 1'h0);
    bus(1'h0, `DCSP_REG_STATUS, 32'h0);
    chk(rd[4:2], 3'h6);
    refGone <= 1'h0;
    dropLock <= 1'h0;
    repeat (4) @(posedge ref_clk);
    bus(1'h0, `DCSP_REG_STATUS, 32'h0);
    chk(rd[3], 1'h0);
    $display("hold and status done");
    bus(1'h1, `DCSP_REG_CTRL, 32'h2);
    stWait();
    chk({rd[4], rd[2]}, 2'h0);
    $display("synthesizer reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
